/* File: rtl/fcd_pkg.sv */
// Constants, field layouts and types of the command word decoder.
// Assumes a single 20 MHz system clock and an AXI4-Lite register master.
package fcd_pkg;
   localparam int unsigned CLK_HZ      = 20_000_000;
   localparam int unsigned BAUD        = 300;
   localparam int unsigned OVERSAMPLE  = 16;
   localparam int unsigned TICK_CYCLES = CLK_HZ / (BAUD * OVERSAMPLE);
   localparam int unsigned LINE_FAIL_S = 54;
   localparam longint unsigned LINE_FAIL_CYCLES =
      64'(LINE_FAIL_S) * 64'(CLK_HZ);

   localparam int unsigned AXI_AW     = 8;
   localparam logic [7:0] ADDR_CTRL   = 8'h00;
   localparam logic [7:0] ADDR_STATUS = 8'h04;
   localparam logic [7:0] ADDR_TXWORD = 8'h08;
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   localparam logic [3:0] SAMPLE_POINT = 4'h7;
   localparam logic [3:0] RX_LAST_BIT  = 4'ha;
   localparam logic [3:0] TX_LAST_BIT  = 4'ha;
   localparam logic [3:0] SEQ_SEND     = 4'h3;
   localparam logic [3:0] SEQ_HALT     = 4'h8;
   localparam logic [1:0] TX_REPEATS   = 2'h2;
   localparam int unsigned W_CHG       = 5;
   localparam int unsigned N_CHAN      = 6;
   localparam int unsigned N_LINES     = 8;

   typedef struct packed {
      logic spare;
      logic talk;
      logic squelch;
      logic intercom;
   } fcd_fac_s;

   typedef struct packed {
      logic [2:0] shared_output_selector;
      logic       function_polarity_select;
      logic       channel_polarity_select;
   } fcd_ctrl_s;
   localparam fcd_ctrl_s CTRL_RST = 5'h00;

   typedef struct packed {
      logic       key_tone;
      logic       tone_lock;
      logic       line_fail;
      logic [3:0] seq;
      logic       burst;
      logic       chg_flag;
      logic [2:0] chan;
      fcd_fac_s   fac;
   } fcd_status_s;

   typedef enum logic {RX_IDLE = 1'b0, RX_RUN = 1'b1} fcd_rx_e;
   typedef enum logic {TX_IDLE = 1'b0, TX_RUN = 1'b1} fcd_tx_e;
endpackage : fcd_pkg

/* File: rtl/fcd_decoder.sv */
// Serial command burst decoder with facility, channel and reply logic.
// Assumes raw pins on inputs, sys_clk at 20 MHz and an AXI4-Lite master.
// Functional notes
// - Burst is two words, second repeats first.
// - Word: start, eight data, parity, stop.
// - Upper nibble low: low bits drive facilities.
// - Bit five alone high means channel change.
// - Serial data reaches receiver only under lock.
// - Receiver blocked while reply is transmitted.
// - Receiver raises data-available flag per word.
// - Flag cleared half a tick later.
// - Valid word: no errors, check bits low.
// - First word stores nibble, toggles burst state.
// - Second word must match before output update.
// - Intercom, squelch defeat, talkthrough, spare outputs.
// - Talkthrough facility bit needs tone lock.
// - Line fail forces talkthrough on unless squelch defeat is set.
// - Squelch defeat suppresses talkthrough.
// - Line intercom inhibits transmitter keying.
// - Reply nibble: facilities, or received channel bits.
// - Reply bits 4,6,7 low; bit 5 change.
// - First word holds counter; second releases it.
// - Count three sends reply word twice.
// - Counter halts at eight.
// - Matched channel word latches channel, sets flag.
// - Valid word or key tone restarts timer.
// - Silence for 54 seconds asserts line fail.
//
// Decided for this implementation: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ps
module fcd_decoder #(
   parameter int unsigned     TICK_DIV    = fcd_pkg::TICK_CYCLES,
   parameter longint unsigned FAIL_CYCLES = fcd_pkg::LINE_FAIL_CYCLES
) (
   input  wire logic              sys_clk,
   input  wire logic              srst,
   input  wire logic              fsk_data_in,
   input  wire logic              fsk_lock,
   input  wire logic              tone_lock,
   input  wire logic              key_tone,
   output logic                   tx_serial_out,
   output logic                   tx_load_n,
   output logic                   talkthrough_out,
   output logic                   squelch_defeat_out,
   output logic                   line_intercom_out,
   output logic                   tx_inhibit,
   output logic                   spare_out,
   output logic                   line_fail_out,
   output logic                   burst_valid_indicator,
   output logic [7:0]             channel_lines,
   output logic                   shared_out,
   input  wire logic [7:0]        s_axi_awaddr,
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   output logic [1:0]             s_axi_bresp,
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   input  wire logic [7:0]        s_axi_araddr,
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   output logic [31:0]            s_axi_rdata,
   output logic [1:0]             s_axi_rresp,
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready
);
   import fcd_pkg::*;

   if (TICK_DIV < 4) begin : g_bad_tick
      $error("TICK_DIV must be at least 4");
   end
   if (FAIL_CYCLES < 2 || FAIL_CYCLES > 64'hffff_ffff) begin : g_bad_fail
      $error("FAIL_CYCLES must fit 32 bits");
   end

   localparam logic [31:0] TICK_LAST = 32'(TICK_DIV - 1);
   localparam logic [31:0] HALF_TICK = 32'(TICK_DIV / 2);
   localparam logic [31:0] FAIL_LAST = 32'(FAIL_CYCLES - 1);

   // Pin inputs: data, lock, tone lock, key tone.
   logic [3:0] in_meta;
   logic [3:0] in_sync;
   always_ff @(posedge sys_clk) begin
      in_meta <= {key_tone, tone_lock, fsk_lock, fsk_data_in};
      in_sync <= in_meta;
   end
   wire data_s = in_sync[0];
   wire lock_s = in_sync[1];
   wire tone_s = in_sync[2];
   wire key_s  = in_sync[3];

   // Oversample tick and bit-rate enable.
   logic [31:0] tick_cnt;
   logic [3:0]  os_cnt;
   logic        tick;
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         tick_cnt <= '0;
         tick     <= 1'b0;
         os_cnt   <= '0;
      end else begin
         tick     <= (tick_cnt == TICK_LAST);
         tick_cnt <= (tick_cnt == TICK_LAST) ? '0 : tick_cnt + 32'h1;
         if (tick) begin
            os_cnt <= os_cnt + 4'h1;
         end
      end
   end
   wire bit_tick = tick && (os_cnt == 4'hf);

   fcd_tx_e tx_st;
   logic [1:0] tx_pend;
   wire tx_busy = (tx_st == TX_RUN) || (tx_pend != 2'h0);

   // The receiver line idles high when unlocked or while replying.
   wire rx_in = data_s | ~lock_s | tx_busy;

   fcd_rx_e    rx_st;
   logic [3:0] rx_os;
   logic [3:0] rx_bit;
   logic [9:0] rx_sh;
   logic [9:0] rx_word;
   logic       dav;
   logic       dav_clr;
   logic [31:0] half_cnt;

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         rx_st   <= RX_IDLE;
         rx_os   <= '0;
         rx_bit  <= '0;
         rx_sh   <= '0;
         rx_word <= '0;
         dav     <= 1'b0;
      end else begin
         if (dav_clr) begin
            dav <= 1'b0;
         end
         if (tick) begin
            case (rx_st)
               RX_IDLE: begin
                  if (!rx_in) begin
                     rx_st  <= RX_RUN;
                     rx_os  <= '0;
                     rx_bit <= '0;
                  end
               end
               RX_RUN: begin
                  rx_os <= rx_os + 4'h1;
                  if (rx_os == SAMPLE_POINT) begin
                     if (rx_bit == 4'h0 && rx_in) begin
                        rx_st <= RX_IDLE;
                     end else begin
                        rx_sh  <= {rx_in, rx_sh[9:1]};
                        rx_bit <= rx_bit + 4'h1;
                        if (rx_bit == RX_LAST_BIT) begin
                           rx_st   <= RX_IDLE;
                           rx_word <= {rx_in, rx_sh[9:1]};
                           dav     <= 1'b1;
                        end
                     end
                  end
               end
               default: rx_st <= RX_IDLE;
            endcase
         end
      end
   end

   // Flag reset comes half a tick period after the flag rises.
   always_ff @(posedge sys_clk) begin
      if (srst || !dav) begin
         half_cnt <= '0;
         dav_clr  <= 1'b0;
      end else begin
         dav_clr <= (half_cnt == HALF_TICK - 32'h1);
         if (half_cnt != HALF_TICK) begin
            half_cnt <= half_cnt + 32'h1;
         end
      end
   end

   wire [7:0] rx_data           = rx_word[7:0];
   wire       framing_error_flag = ~rx_word[9];
   wire       parity_error_flag  = ~(^rx_word[8:0]);
   wire       checks_low = ~rx_data[4] & ~rx_data[6] & ~rx_data[7];
   wire       word_ok    = ~framing_error_flag & ~parity_error_flag & checks_low;
   wire       word_valid = dav_clr & word_ok;
   wire [3:0] low_nibble_bits = rx_data[3:0];
   wire       is_chg = rx_data[W_CHG];

   logic       burst;
   logic [3:0] stored;
   fcd_fac_s   fac;
   logic       chg_flag;
   logic [2:0] chan;
   wire        nib_match = (stored == low_nibble_bits);

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         burst    <= 1'b0;
         stored   <= '0;
         fac      <= '0;
         chg_flag <= 1'b0;
         chan     <= '0;
      end else if (word_valid) begin
         burst <= ~burst;
         if (!burst) begin
            stored <= low_nibble_bits;
         end else if (nib_match) begin
            if (is_chg) begin
               chan     <= low_nibble_bits[2:0];
               chg_flag <= 1'b1;
            end else begin
               fac      <= fcd_fac_s'(low_nibble_bits);
               chg_flag <= 1'b0;
            end
         end
      end
   end

   // Reply sequence counter.
   logic [3:0] seq;
   logic       seq_hold;
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         seq      <= SEQ_HALT;
         seq_hold <= 1'b0;
      end else if (word_valid) begin
         if (!burst) begin
            seq      <= '0;
            seq_hold <= 1'b1;
         end else begin
            seq_hold <= 1'b0;
         end
      end else if (bit_tick && !seq_hold && seq != SEQ_HALT) begin
         seq <= seq + 4'h1;
      end
   end
   wire send_go = bit_tick && !seq_hold && !word_valid && (seq == SEQ_SEND - 4'h1);

   wire [3:0] reply_nib = chg_flag ? low_nibble_bits : fac;
   wire       channel_change_flag_bit = chg_flag;
   wire [7:0] tx_word = {2'b00, channel_change_flag_bit, 1'b0, reply_nib};

   logic [9:0] tx_sh;
   logic [3:0] tx_cnt;
   logic       tx_out;
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         tx_st     <= TX_IDLE;
         tx_pend   <= '0;
         tx_sh     <= '1;
         tx_cnt    <= '0;
         tx_out    <= 1'b1;
         tx_load_n <= 1'b1;
      end else begin
         tx_load_n <= 1'b1;
         if (send_go) begin
            tx_pend <= TX_REPEATS;
         end
         case (tx_st)
            TX_IDLE: begin
               if (bit_tick && tx_pend != 2'h0 && !send_go) begin
                  tx_load_n <= 1'b0;
                  tx_pend   <= tx_pend - 2'h1;
                  tx_st     <= TX_RUN;
                  tx_out    <= 1'b0;
                  tx_sh     <= {1'b1, ~(^tx_word), tx_word};
                  tx_cnt    <= '0;
               end
            end
            TX_RUN: begin
               if (bit_tick) begin
                  if (tx_cnt == TX_LAST_BIT - 4'h1 + 4'h1) begin
                     tx_st <= TX_IDLE;
                  end else begin
                     tx_out <= tx_sh[0];
                     tx_sh  <= {1'b1, tx_sh[9:1]};
                     tx_cnt <= tx_cnt + 4'h1;
                  end
               end
            end
            default: tx_st <= TX_IDLE;
         endcase
      end
   end

   // Line-fail timer.
   logic [31:0] lf_cnt;
   logic        line_fail;
   always_ff @(posedge sys_clk) begin
      if (srst || word_valid || key_s) begin
         lf_cnt    <= '0;
         line_fail <= 1'b0;
      end else if (!line_fail) begin
         if (lf_cnt == FAIL_LAST) begin
            line_fail <= 1'b1;
         end else begin
            lf_cnt <= lf_cnt + 32'h1;
         end
      end
   end

   fcd_ctrl_s ctrl;
   wire [7:0] next_lines;
   for (genvar i = 0; i < N_LINES; i++) begin : g_line
      localparam logic [2:0] CODE = 3'(i + 1);
      wire pol = (i < N_CHAN) ? ctrl.channel_polarity_select
                              : ctrl.function_polarity_select;
      assign next_lines[i] = (chan == CODE) ^ pol;
   end
   wire next_talk = ((fac.talk & tone_s) | line_fail) & ~fac.squelch;
   wire next_shared = next_lines[ctrl.shared_output_selector];

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         talkthrough_out       <= 1'b0;
         squelch_defeat_out    <= 1'b0;
         line_intercom_out     <= 1'b0;
         tx_inhibit            <= 1'b0;
         spare_out             <= 1'b0;
         line_fail_out         <= 1'b0;
         burst_valid_indicator <= 1'b0;
         channel_lines         <= '0;
         shared_out            <= 1'b0;
         tx_serial_out         <= 1'b1;
      end else begin
         talkthrough_out       <= next_talk;
         squelch_defeat_out    <= fac.squelch;
         line_intercom_out     <= fac.intercom;
         tx_inhibit            <= fac.intercom;
         spare_out             <= fac.spare;
         line_fail_out         <= line_fail;
         burst_valid_indicator <= word_valid;
         channel_lines         <= next_lines;
         shared_out            <= next_shared;
         tx_serial_out         <= tx_out;
      end
   end

   // AXI4-Lite slave.
   logic [7:0]  aw_q;
   logic [31:0] w_q;
   logic [3:0]  ws_q;
   logic        aw_got;
   logic        w_got;
   wire fcd_status_s status = {key_s, tone_s, line_fail, seq, burst,
                               chg_flag, chan, fac};
   wire        wr_go   = aw_got && w_got && !s_axi_bvalid;
   wire        wr_ctrl = (aw_q == ADDR_CTRL);
   wire        wr_ok   = wr_ctrl || aw_q == ADDR_STATUS || aw_q == ADDR_TXWORD;
   wire        rd_ok   = s_axi_araddr == ADDR_CTRL || s_axi_araddr == ADDR_STATUS
                         || s_axi_araddr == ADDR_TXWORD;
   wire [31:0] rd_val  = (s_axi_araddr == ADDR_CTRL)   ? 32'(ctrl) :
                         (s_axi_araddr == ADDR_STATUS) ? 32'(status) :
                         (s_axi_araddr == ADDR_TXWORD) ? 32'(tx_word) : 32'h0;

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= RESP_OKAY;
         aw_got        <= 1'b0;
         w_got         <= 1'b0;
         aw_q          <= '0;
         w_q           <= '0;
         ws_q          <= '0;
         ctrl          <= CTRL_RST;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_got        <= 1'b1;
            aw_q          <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end else if (!aw_got && !s_axi_bvalid) begin
            s_axi_awready <= 1'b1;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_got        <= 1'b1;
            w_q          <= s_axi_wdata;
            ws_q         <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
         end else if (!w_got && !s_axi_bvalid) begin
            s_axi_wready <= 1'b1;
         end
         if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
            if (wr_ctrl && ws_q[0]) begin
               ctrl <= fcd_ctrl_s'(w_q[4:0]);
            end
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            aw_got       <= 1'b0;
            w_got        <= 1'b0;
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= '0;
         s_axi_rresp   <= RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b1;
         s_axi_rdata   <= rd_val;
         s_axi_rresp   <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end else if (!s_axi_rvalid) begin
         s_axi_arready <= 1'b1;
      end
   end

   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (srst);

   chk_valid_on_clear: assert property (
      word_valid |-> dav && dav_clr && !rx_data[7] && !rx_data[6] && !rx_data[4])
      else $error("valid pulse without flag reset or checks");
   chk_flag_reset: assert property (dav_clr |=> !dav && !dav_clr)
      else $error("data flag not cleared by its reset");
   chk_rx_gating: assert property (
      (rx_st == RX_IDLE && (!lock_s || tx_busy)) |=> rx_st == RX_IDLE)
      else $error("receiver started while blocked");
   chk_tx_blocks_rx: assert property (tx_load_n == 1'b0 |-> ##1 tx_busy[*3])
      else $error("transmit not marked busy");
   chk_counter_halt: assert property (
      (seq == SEQ_HALT && !word_valid) |=> seq == SEQ_HALT)
      else $error("counter left its halt");
   chk_counter_release: assert property (
      (word_valid && burst) |=> !seq_hold && seq == $past(seq))
      else $error("second word did not release counter");
   chk_double_send: assert property (send_go |=> tx_pend == TX_REPEATS)
      else $error("reply not queued twice at count three");
   chk_fac_update: assert property (
      (word_valid && burst && nib_match && !is_chg)
      |=> fac == $past(low_nibble_bits) && !chg_flag)
      else $error("facility register not updated on match");
   chk_fac_hold: assert property (
      (word_valid && burst && !nib_match) |=> $stable(fac) && $stable(chan))
      else $error("mismatched burst changed outputs");
   chk_squelch_prio: assert property (fac.squelch |=> !talkthrough_out)
      else $error("talkthrough active under squelch defeat");
   chk_line_fail_talk: assert property (
      (line_fail && !fac.squelch) |=> talkthrough_out)
      else $error("line fail did not force talkthrough");
   chk_reply_bit5: assert property (tx_word[5] == chg_flag && tx_word[7:6] == 2'b00)
      else $error("reply check bits wrong");
   chk_chan_latch: assert property (
      (word_valid && burst && nib_match && is_chg)
      |=> chan == $past(low_nibble_bits[2:0]) && chg_flag)
      else $error("channel not latched");
   chk_timer_restart: assert property ((word_valid || key_s) |=> !line_fail)
      else $error("line fail timer not restarted");
endmodule : fcd_decoder

/* File: tb/fcd_line_ctl.sv */
// Model of the remote line controller that sends command words and hears replies.
// Assumes the caller enters send_word just after a rising sys_clk edge.
`timescale 1ns/1ps
module fcd_line_ctl #(
   parameter int unsigned TICK_DIV = 8
) (
   input  wire logic sys_clk,
   input  wire logic tx_serial_out,
   input  wire logic tx_load_n,
   output logic      fsk_data_in
);
   logic [10:0] reply = '1;

   initial fsk_data_in = 1'b1;

   // Each reply frame is sampled mid-bit, timed from the load strobe that starts it.
   always @(posedge sys_clk) begin
      if (tx_load_n === 1'b0) begin
         repeat (8 * TICK_DIV) @(posedge sys_clk);
         for (int i = 0; i < 11; i++) begin
            reply[i] = tx_serial_out;
            repeat (16 * TICK_DIV) @(posedge sys_clk);
         end
      end
   end

   // Start low, data LSB first, odd parity (bad_par flips it), stop high.
   task automatic send_word(input logic [7:0] w, input logic bad_par);
      logic [10:0] f;
      f = {1'b1, (~^w) ^ bad_par, w, 1'b0};
      for (int i = 0; i < 11; i++) begin
         fsk_data_in <= f[i];
         repeat (16 * TICK_DIV) @(posedge sys_clk);
      end
   endtask : send_word
endmodule : fcd_line_ctl

/* File: tb/fsk_command_word_decoder_tb.sv */
// Self-checking bench of the command word decoder.
// Assumes the decoder carries its own assertions and the line model drives its input.
`timescale 1ns/1ps
module fsk_command_word_decoder_tb;
   import fcd_pkg::*;
   localparam int unsigned TD = 8;
   localparam int unsigned BT = 16 * TD;
   typedef struct packed {
      logic [7:0] w;
      logic       tl;
      logic [4:0] fo;
      logic [7:0] tx;
   } fcd_row_s;
   logic sys_clk = 1'b0, srst = 1'b1, fsk_lock = 1'b1, tone_lock = 1'b1, key_tone = 1'b1;
   logic fsk_data_in, tx_serial_out, tx_load_n, talkthrough_out, squelch_defeat_out;
   logic line_intercom_out, tx_inhibit, spare_out, line_fail_out, burst_valid_indicator;
   logic shared_out, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [7:0] channel_lines, s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic [1:0] s_axi_bresp, s_axi_rresp, r;
   logic [3:0] s_axi_wstrb = 4'hf;
   int bad_count = 0, n_tests = 0, n_ld = 0, n_vld = 0;
   // Facility view is {spare, talkthrough, squelch, intercom, inhibit}.
   fcd_row_s rows [6] = '{'{8'h01, 1'b1, 5'h03, 8'h01}, '{8'h04, 1'b1, 5'h08, 8'h04},
      '{8'h04, 1'b0, 5'h00, 8'h04}, '{8'h06, 1'b1, 5'h04, 8'h06},
      '{8'h08, 1'b1, 5'h10, 8'h08}, '{8'h23, 1'b1, 5'h10, 8'h23}};
   wire [4:0] fo = {spare_out, talkthrough_out, squelch_defeat_out, line_intercom_out,
                    tx_inhibit};

   fcd_line_ctl #(.TICK_DIV(TD)) ctl (.sys_clk, .tx_serial_out, .tx_load_n, .fsk_data_in);
   fcd_decoder #(.TICK_DIV(TD), .FAIL_CYCLES(64'd2000)) dut (
      .sys_clk, .srst, .fsk_data_in, .fsk_lock, .tone_lock, .key_tone, .tx_serial_out,
      .tx_load_n, .talkthrough_out, .squelch_defeat_out, .line_intercom_out, .tx_inhibit,
      .spare_out, .line_fail_out, .burst_valid_indicator, .channel_lines, .shared_out,
      .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready);

   always #25 sys_clk = ~sys_clk;

   always @(posedge sys_clk) begin
      if (tx_load_n === 1'b0) n_ld++;
      if (burst_valid_indicator === 1'b1) n_vld++;
   end

   task end_sim;
      $display("comparisons %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : end_sim

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         bad_count++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic tmo;
      bad_count++;
      $display("CHECK FAILED at %0t: bus wait ran out", $time);
      end_sim();
   endtask : tmo

   task automatic axi_wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
      int n;
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      for (n = 0; n < 64; n++) begin
         @(posedge sys_clk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid) break;
      end
      rs = s_axi_bresp;
      s_axi_bready <= 1'b0;
      if (n == 64) tmo();
      @(posedge sys_clk);
   endtask : axi_wr

   task automatic axi_rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
      int n;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      for (n = 0; n < 64; n++) begin
         @(posedge sys_clk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid) break;
      end
      v = s_axi_rdata;
      rs = s_axi_rresp;
      s_axi_rready <= 1'b0;
      if (n == 64) tmo();
      @(posedge sys_clk);
   endtask : axi_rd

   // Window long enough for the counter to reach its halt and both replies to go out.
   task automatic burst(input logic [7:0] a, input logic [7:0] b);
      n_ld = 0;
      n_vld = 0;
      ctl.send_word(a, 1'b0);
      ctl.send_word(b, 1'b0);
      repeat (30 * BT) @(posedge sys_clk);
   endtask : burst

   initial begin
      repeat (3) @(posedge sys_clk);
      srst <= 1'b0;
      repeat (2) @(posedge sys_clk);
      foreach (rows[i]) begin
         tone_lock <= rows[i].tl;
         burst(rows[i].w, rows[i].w);
         chk(32'(fo), 32'(rows[i].fo));
         chk(32'(n_ld), 32'd2);
         chk(32'(n_vld), 32'd2);
         chk(32'(ctl.reply), 32'({1'b1, ~^rows[i].tx, rows[i].tx, 1'b0}));
         axi_rd(ADDR_TXWORD, d, r);
         chk(32'(d[7:0]), 32'(rows[i].tx));
         $display("row %0d done", i);
      end
      chk(32'(channel_lines), 32'h04);
      axi_rd(ADDR_STATUS, d, r);
      chk(32'(d[12:4]), 32'h10b);
      burst(8'h01, 8'h02);
      chk(32'(fo), 32'h10);
      $display("mismatch done");
      n_vld = 0;
      ctl.send_word(8'h01, 1'b0);
      ctl.send_word(8'h81, 1'b0);
      ctl.send_word(8'h02, 1'b1);
      chk(32'(n_vld), 32'd1);
      burst(8'h01, 8'h01);
      chk(32'(fo), 32'h03);
      $display("validity done");
      fsk_lock <= 1'b0;
      burst(8'h04, 8'h04);
      chk(32'(fo), 32'h03);
      chk(32'(n_ld), 32'd0);
      fsk_lock <= 1'b1;
      $display("lock done");
      axi_wr(ADDR_CTRL, 32'h9, r);
      chk(32'(r), 32'(RESP_OKAY));
      axi_rd(ADDR_CTRL, d, r);
      chk(d, 32'h9);
      chk(32'(channel_lines), 32'h3b);
      chk(32'(shared_out), 32'h0);
      axi_rd(8'h10, d, r);
      chk(32'(r), 32'(RESP_SLVERR));
      chk(d, 32'h0);
      axi_wr(ADDR_CTRL, 32'h1e, r);
      chk(32'({channel_lines, shared_out}), 32'h189);
      $display("register done");
      key_tone <= 1'b0;
      repeat (2100) @(posedge sys_clk);
      chk(32'({line_fail_out, talkthrough_out}), 32'h3);
      key_tone <= 1'b1;
      repeat (5) @(posedge sys_clk);
      chk(32'(line_fail_out), 32'h0);
      $display("line fail done");
      srst <= 1'b1;
      repeat (3) @(posedge sys_clk);
      chk(32'({line_intercom_out, tx_load_n, tx_serial_out}), 32'h3);
      srst <= 1'b0;
      repeat (2) @(posedge sys_clk);
      axi_rd(ADDR_STATUS, d, r);
      chk(32'(d[12:0]), 32'h1000);
      $display("reset done");
      end_sim();
   end
endmodule : fsk_command_word_decoder_tb
